// *** pmt_pkg.sv ***
// Package of constants for the 8-bit period match timer
package pmt_pkg;

   // Register indices on the plain register port
   localparam logic [2:0] ADDR_COUNT   = 3'h0;
   localparam logic [2:0] ADDR_LIMIT   = 3'h1;
   localparam logic [2:0] ADDR_CONTROL = 3'h2;
   localparam logic [2:0] ADDR_STATUS  = 3'h3;
   localparam logic [2:0] ADDR_MASK    = 3'h4;

   // Control field positions
   localparam int PRESC_LSB = 0;
   localparam int RUN_BIT   = 2;
   localparam int POST_LSB  = 3;
   localparam int POST_MSB  = 6;

   // Status and mask bit positions
   localparam int STAT_FLAG  = 0;
   localparam int STAT_MATCH = 1;

   // Reset values
   localparam logic [7:0] COUNT_RST  = 8'h00;
   localparam logic [7:0] LIMIT_RST  = 8'hFF;
   localparam logic [6:0] CTRL_RST   = 7'h00;
   localparam logic [1:0] STAT_RST   = 2'h0;
   localparam logic [3:0] POST_RST   = 4'h0;
   localparam logic [3:0] PRESC_RST  = 4'h0;

   // Prescale selections
   localparam logic [1:0] PRESC_DIV1 = 2'h0;
   localparam logic [1:0] PRESC_DIV4 = 2'h1;
   localparam logic [1:0] PRESC_DIV4_LAST  = 2'h3;
   localparam logic [3:0] PRESC_DIV16_LAST = 4'hF;

   // Instruction clock is the oscillator clock divided by four
   localparam int OSC_PERIOD_NS   = 10;
   localparam int INSTR_PERIOD_NS = 40;
   localparam int INSTR_DIV       = INSTR_PERIOD_NS / OSC_PERIOD_NS;
   localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
   localparam logic [1:0] INSTR_RST  = 2'h0;

endpackage : pmt_pkg

// *** pmt_prescaler.sv ***
// Clock prescaler of the period match timer: divide by 1, 4 or 16
`timescale 1ns/1ps
module pmt_prescaler (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       clear,
   input  wire logic       in_tick,
   input  wire logic [1:0] select,
   output logic            out_tick
);
   import pmt_pkg::*;

   logic [3:0] cnt;
   logic [3:0] next_cnt;
   wire        sel_div1;
   wire        sel_div4;
   wire        sel_div16;

   assign sel_div1  = (select == PRESC_DIV1);
   assign sel_div4  = (select == PRESC_DIV4);
   assign sel_div16 = select[1];

   // Upper select bit alone picks divide by 16
   assign out_tick = in_tick & (sel_div1 |
                     (sel_div4 & (cnt[1:0] == PRESC_DIV4_LAST)) |
                     (sel_div16 & (cnt == PRESC_DIV16_LAST)));

   assign next_cnt = clear   ? PRESC_RST :
                     in_tick ? cnt + 4'h1 : cnt;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt <= PRESC_RST;
      end else begin
         cnt <= next_cnt;
      end
   end

endmodule : pmt_prescaler

// *** pmt_timer.sv ***
// Top of the 8-bit period match timer with register port and interrupt
//
// Function
// - Count increments from zero on prescaled ticks
// - Prescale field selects divide 1, 4, 16
// - Compare count with period every cycle
// - Match clears count next, advances postscaler
// - Count and period are read/write registers
// - Reset: count zero, period all ones
// - Count/control write or reset clears scalers
// - Control write leaves count unchanged
// - Postscale field: matches per flag minus one
// - Run bit enables counting, off saves power
// - Control bit 7 reads zero, resets zero
// - Match based interrupt request provided
// - Match output offered as serial shift clock
// - Postscaler at ratio latches match flag
// - Flag forwarded only when enabled
// - Unscaled match offered as PWM time base
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module pmt_timer (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   output logic            irq,
   output logic            match_out,
   output logic            shift_clk
);
   import pmt_pkg::*;

   // Register state
   logic [7:0] period_count;
   logic [7:0] period_limit;
   logic [6:0] timer_control;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic [3:0] post_cnt;
   logic [1:0] instr_phase;

   // Next values
   logic [7:0] next_count;
   logic [3:0] next_post;
   logic [1:0] next_status;
   logic [7:0] next_rdata;

   // Decoding of the register port
   function automatic logic reg_hit(input logic       strobe,
                                    input logic [2:0] addr,
                                    input logic [2:0] target);
      reg_hit = strobe & (addr == target);
   endfunction : reg_hit

   wire wr_count   = reg_hit(reg_write, reg_addr, ADDR_COUNT);
   wire wr_limit   = reg_hit(reg_write, reg_addr, ADDR_LIMIT);
   wire wr_control = reg_hit(reg_write, reg_addr, ADDR_CONTROL);
   wire wr_status  = reg_hit(reg_write, reg_addr, ADDR_STATUS);
   wire wr_mask    = reg_hit(reg_write, reg_addr, ADDR_MASK);

   // Control fields
   wire [1:0] prescale_select  = timer_control[PRESC_LSB +: 2];
   wire       timer_run        = timer_control[RUN_BIT];
   wire [3:0] postscale_select = timer_control[POST_MSB:POST_LSB];

   // Scaler clear on count write, control write; reset handled in flops
   wire scaler_clear = wr_count | wr_control;

   // Instruction clock: one tick every fourth oscillator cycle
   wire instr_tick = (instr_phase == INSTR_LAST);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         instr_phase <= INSTR_RST;
      end else begin
         instr_phase <= instr_phase + 2'h1;
      end
   end

   // Prescaler sees no ticks while stopped, so it holds and idles
   wire presc_in = instr_tick & timer_run;
   wire tmr_tick;

   pmt_prescaler u_prescaler (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .clear    (scaler_clear),
      .in_tick  (presc_in),
      .select   (prescale_select),
      .out_tick (tmr_tick)
   );

   // Comparator runs every cycle; the event is taken on a timer tick
   wire count_equal = (period_count == period_limit);
   wire match_evt   = tmr_tick & count_equal;
   wire post_at_ratio = (post_cnt == postscale_select);
   wire flag_evt    = match_evt & post_at_ratio;

   // Software write wins over a coincident tick
   always_comb begin
      if (wr_count) begin
         next_count = reg_wdata;
      end else if (match_evt) begin
         next_count = COUNT_RST;
      end else if (tmr_tick) begin
         next_count = period_count + 8'h01;
      end else begin
         next_count = period_count;
      end
   end

   always_comb begin
      if (scaler_clear) begin
         next_post = POST_RST;
      end else if (flag_evt) begin
         next_post = POST_RST;
      end else if (match_evt) begin
         next_post = post_cnt + 4'h1;
      end else begin
         next_post = post_cnt;
      end
   end

   // Sticky status: set wins over write-one-to-clear
   wire [1:0] status_set = {match_evt, flag_evt};
   wire [1:0] status_clr = wr_status ? reg_wdata[1:0] : 2'h0;

   always_comb begin
      next_status = (irq_status & ~status_clr) | status_set;
   end

   // Read mux; unmapped indices read as zero
   always_comb begin
      unique case (reg_addr)
         ADDR_COUNT:   next_rdata = period_count;
         ADDR_LIMIT:   next_rdata = period_limit;
         ADDR_CONTROL: next_rdata = {1'b0, timer_control};
         ADDR_STATUS:  next_rdata = {6'h00, irq_status};
         ADDR_MASK:    next_rdata = {6'h00, irq_mask};
         default:      next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         period_count <= COUNT_RST;
         post_cnt     <= POST_RST;
      end else begin
         period_count <= next_count;
         post_cnt     <= next_post;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         period_limit  <= LIMIT_RST;
         timer_control <= CTRL_RST;
         irq_mask      <= STAT_RST;
      end else begin
         if (wr_limit) begin
            period_limit <= reg_wdata;
         end
         if (wr_control) begin
            timer_control <= reg_wdata[6:0];
         end
         if (wr_mask) begin
            irq_mask <= reg_wdata[1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_status <= STAT_RST;
         irq       <= 1'b0;
      end else begin
         irq_status <= next_status;
         // Flag latches regardless; only the request is gated
         irq       <= |(irq_status & irq_mask);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
         match_out <= 1'b0;
         shift_clk <= 1'b0;
      end else begin
         reg_rdata <= reg_read ? next_rdata : 8'h00;
         // Unscaled pulse for compare units as a PWM time base
         match_out <= match_evt;
         // Toggle gives a square shift clock at half the match rate
         if (match_evt) begin
            shift_clk <= ~shift_clk;
         end
      end
   end

   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence seq_match;
      tmr_tick && count_equal && !wr_count;
   endsequence

   sequence seq_plain_tick;
      tmr_tick && !count_equal && !wr_count;
   endsequence

   sequence seq_idle;
      !timer_run && !reg_write;
   endsequence

   chk_count_wrap: assert property (
      seq_match |=> period_count == COUNT_RST)
      else $error("count not cleared after match");

   chk_count_incr: assert property (
      seq_plain_tick |=> period_count == $past(period_count) + 8'h01)
      else $error("count did not increment on tick");

   chk_match_out: assert property (
      match_evt |=> match_out ##1 (!match_out || $past(match_evt)))
      else $error("match output not one pulse per match");

   chk_ctrl_keeps: assert property (
      wr_control && !tmr_tick |=> period_count == $past(period_count))
      else $error("control write changed count");

   // Divide by 1 keeps no prescale state, so a tick may follow a clear
   chk_post_clear: assert property (
      scaler_clear |=> post_cnt == POST_RST
                       && (!tmr_tick || prescale_select == PRESC_DIV1))
      else $error("scalers not cleared by write");

   chk_stop_hold: assert property (
      seq_idle ##1 seq_idle |-> $stable(period_count) && !match_evt
                                && $stable(post_cnt))
      else $error("stopped timer changed state");

   chk_post_ratio: assert property (
      match_evt && post_at_ratio && !scaler_clear
      |=> irq_status[STAT_FLAG] && post_cnt == POST_RST)
      else $error("postscaler ratio missed flag");

   chk_flag_only: assert property (
      $rose(irq_status[STAT_FLAG]) |-> $past(flag_evt))
      else $error("flag set without postscaler event");

   chk_irq_gate: assert property (
      ##1 irq |-> $past(|(irq_status & irq_mask)))
      else $error("interrupt without enabled flag");

   chk_read_count: assert property (
      reg_read && reg_addr == ADDR_COUNT |=> reg_rdata == $past(period_count))
      else $error("count read data wrong");

   chk_ctrl_msb: assert property (
      reg_read && reg_addr == ADDR_CONTROL |=> !reg_rdata[7])
      else $error("control bit 7 not zero");

   chk_reset_vals: assert property (
      @(posedge clk) disable iff (1'b0)
      sys_rst |=> period_count == COUNT_RST && period_limit == LIMIT_RST)
      else $error("reset values wrong");

   chk_shift_clk: assert property (
      match_evt |=> shift_clk != $past(shift_clk))
      else $error("shift clock did not toggle");

   chk_div16: assert property (
      tmr_tick && prescale_select[1] && !scaler_clear
      |=> (!tmr_tick || prescale_select == PRESC_DIV1) [*8])
      else $error("divide by 16 ticked too soon");

   // Register port, scaler, status and output checks

   chk_count_write: assert property (
      wr_count |=> period_count == $past(reg_wdata))
      else $error("count write not taken");

   chk_limit_write: assert property (
      wr_limit |=> period_limit == $past(reg_wdata))
      else $error("period write not taken");

   chk_read_limit: assert property (
      reg_read && reg_addr == ADDR_LIMIT |=> reg_rdata == $past(period_limit))
      else $error("period read data wrong");

   chk_rdata_idle: assert property (
      !reg_read |=> reg_rdata == 8'h00)
      else $error("read data not zero outside read");

   chk_ctrl_write: assert property (
      wr_control |=> timer_control == $past(reg_wdata[6:0]))
      else $error("control write not taken");

   chk_reset_ctrl: assert property (
      @(posedge clk) disable iff (1'b0)
      sys_rst |=> timer_control == CTRL_RST && post_cnt == POST_RST
                  && irq_status == STAT_RST && !irq)
      else $error("control or scaler not reset");

   chk_tick_gap: assert property (
      tmr_tick |=> !tmr_tick [*3])
      else $error("ticks faster than instruction clock");

   chk_run_div1: assert property (
      timer_run && prescale_select == PRESC_DIV1 && instr_tick && !count_equal
      && !wr_count |=> period_count == $past(period_count) + 8'h01)
      else $error("running timer did not count");

   chk_div4: assert property (
      tmr_tick && prescale_select == PRESC_DIV4 && !scaler_clear
      |=> (!tmr_tick || prescale_select == PRESC_DIV1) [*8])
      else $error("divide by 4 ticked too soon");

   chk_match_equal: assert property (
      match_out |-> $past(count_equal))
      else $error("match output without equal count");

   chk_no_match: assert property (
      tmr_tick && !count_equal |=> !match_out)
      else $error("match output on unequal count");

   chk_post_step: assert property (
      match_evt && !post_at_ratio && !scaler_clear
      |=> post_cnt == $past(post_cnt) + 4'h1)
      else $error("postscaler did not advance on match");

   chk_post_idle: assert property (
      !match_evt && !scaler_clear |=> $stable(post_cnt))
      else $error("postscaler moved without match");

   chk_match_status: assert property (
      match_evt |=> irq_status[STAT_MATCH])
      else $error("match status not set");

   chk_status_w1c: assert property (
      wr_status && !match_evt
      |=> irq_status == ($past(irq_status) & ~$past(reg_wdata[1:0])))
      else $error("status write one to clear wrong");

   chk_irq_level: assert property (
      (|(irq_status & irq_mask)) |=> irq)
      else $error("interrupt missing for enabled flag");

   chk_irq_low: assert property (
      !(|(irq_status & irq_mask)) |=> !irq)
      else $error("interrupt high without enabled flag");

   chk_shift_hold: assert property (
      !match_evt |=> $stable(shift_clk))
      else $error("shift clock moved without match");

endmodule : pmt_timer

// *** test_pmt_timer.sv ***
// Self-checking testbench of the 8-bit period match timer
`timescale 1ns/1ps
module test_pmt_timer;
   import pmt_pkg::*;
   logic       clk;
   logic       sys_rst;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_write;
   logic       reg_read;
   logic [7:0] reg_rdata;
   logic       irq;
   logic       match_out;
   logic       shift_clk;
   int         errors      = 0;
   int         check_count = 0;
   int         cycles      = 0;

   pmt_timer i_pmt_timer (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .irq(irq), .match_out(match_out), .shift_clk(shift_clk)
   );

   // Clock cycles between matches: instruction clock, prescale, limit plus one
   function automatic int period(input logic [1:0] p, input logic [7:0] lim);
      int div;
      div = (p == 2'h0) ? 1 : (p == 2'h1) ? 4 : 16;
      return 4 * div * (int'(lim) + 1);
   endfunction : period

   task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_byte

   task automatic chk_num(input string name, input int exp, input int got);
      check_count++;
      if (got != exp) begin
         errors++;
         $display("FAIL %s expected %0d seen %0d", name, exp, got);
      end
   endtask : chk_num

   // One idle cycle between strobes keeps each strobe a single assignment per step
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr

   task automatic chk_reg(input string name, input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      chk_byte(name, exp, reg_rdata);
   endtask : chk_reg

   task automatic wait_match(input int limit, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (match_out !== 1'b1 && n < limit);
   endtask : wait_match

   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Whole run needs well under ten thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         tally_and_finish();
      end
   end

   initial begin
      int         n;
      int         post;
      logic [7:0] d;
      logic [7:0] lim;
      logic       sc;
      sys_rst   = 1'b1;
      reg_addr  = 3'h0;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read  = 1'b0;
      d = 8'($urandom(70));
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      chk_reg("count", ADDR_COUNT, 8'h00);
      chk_reg("limit", ADDR_LIMIT, 8'hFF);
      chk_reg("control", ADDR_CONTROL, 8'h00);
      chk_reg("status", ADDR_STATUS, 8'h00);
      chk_byte("irq", 8'h00, {7'h00, irq});
      $display("Test reset done");
      for (int k = 0; k < 8; k++) begin
         d = 8'($urandom);
         wr(ADDR_LIMIT, d);
         chk_reg("limit", ADDR_LIMIT, d);
         wr(ADDR_CONTROL, d & 8'hFB);
         chk_reg("control", ADDR_CONTROL, d & 8'h7B);
         wr(ADDR_COUNT, ~d);
         chk_reg("count", ADDR_COUNT, ~d);
         wr(3'(5 + k % 3), d);
         chk_reg("unmapped", 3'(5 + k % 3), 8'h00);
      end
      $display("Test registers done");
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_COUNT, 8'h5A);
      wr(ADDR_LIMIT, 8'h5B);
      n = 0;
      repeat (300) begin
         @(posedge clk);
         #1;
         if (match_out === 1'b1) n++;
      end
      chk_num("stopped matches", 0, n);
      chk_reg("held count", ADDR_COUNT, 8'h5A);
      wr(ADDR_CONTROL, 8'h78);
      chk_reg("count kept", ADDR_COUNT, 8'h5A);
      wr(ADDR_CONTROL, 8'h04);
      wait_match(40, n);
      chk_num("early match", 1, int'(n <= 10));
      $display("Test stop and hold done");
      for (int p = 0; p < 4; p++) begin
         lim = 8'($urandom_range(7));
         if (p == 0) lim = 8'hFF;
         if (p == 3) lim = 8'h00;
         wr(ADDR_CONTROL, 8'h00);
         wr(ADDR_COUNT, 8'h00);
         wr(ADDR_LIMIT, lim);
         wr(ADDR_CONTROL, {5'h00, 1'b1, 2'(p)});
         wait_match(3000, n);
         sc = shift_clk;
         wait_match(3000, n);
         chk_num("match period", period(2'(p), lim), n);
         chk_byte("shift clock", {7'h00, ~sc}, {7'h00, shift_clk});
      end
      $display("Test periods done");
      for (int k = 0; k < 4; k++) begin
         post = (k == 0) ? 0 : (k == 1) ? 15 : int'($urandom_range(14, 1));
         wr(ADDR_CONTROL, 8'h00);
         wr(ADDR_COUNT, 8'h00);
         wr(ADDR_LIMIT, 8'h00);
         wr(ADDR_MASK, 8'h01);
         wr(ADDR_STATUS, 8'h03);
         wr(ADDR_CONTROL, {1'b0, 4'(post), 3'b100});
         n = 0;
         for (int c = 0; c < 200 && irq !== 1'b1; c++) begin
            @(posedge clk);
            #1;
            if (match_out === 1'b1) n++;
         end
         chk_num("matches per flag", post + 1, n);
         wr(ADDR_CONTROL, 8'h00);
         chk_reg("status", ADDR_STATUS, 8'h03);
         wr(ADDR_STATUS, 8'h01);
         chk_reg("status cleared", ADDR_STATUS, 8'h02);
         chk_byte("irq cleared", 8'h00, {7'h00, irq});
      end
      wr(ADDR_MASK, 8'h00);
      wr(ADDR_STATUS, 8'h03);
      wr(ADDR_CONTROL, 8'h04);
      repeat (40) @(posedge clk);
      #1;
      chk_byte("masked irq", 8'h00, {7'h00, irq});
      wr(ADDR_CONTROL, 8'h00);
      chk_reg("masked status", ADDR_STATUS, 8'h03);
      $display("Test postscale and interrupt done");
      tally_and_finish();
   end
endmodule : test_pmt_timer
